// [rtl/ddt_dual_down_timer.sv]
// dual down timer with seven modes and one reserved mode code, clock source selection and apb register access
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "ddt_timer_map.svh"

module ddt_dual_down_timer (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire ddt_pkg::ddt_addr_t paddr,
   input wire ddt_pkg::ddt_word_t pwdata,
   output ddt_pkg::ddt_word_t prdata,
   output logic pready,
   output logic pslverr,
   // counting clock sources, taken as plain levels
   input wire logic rcFastClk,
   input wire logic lowPowerClk,
   input wire logic crystalClk,
   input wire logic rcSlowClk,
   input wire logic generalPinTwo,
   // status to the chip
   output logic bitRateTick,
   output logic [2:0] systemClockDivider
);
   import ddt_pkg::*;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // register index of an address, 7 for an unmapped one
   function automatic logic [2:0] ddtIndex(input ddt_addr_t a);
      unique case (a)
         `DDT_OFS_CONTROL: ddtIndex = 3'h0;
         `DDT_OFS_MODE: ddtIndex = 3'h1;
         `DDT_OFS_T0_LOW: ddtIndex = 3'h2;
         `DDT_OFS_T0_HIGH: ddtIndex = 3'h3;
         `DDT_OFS_T1_LOW: ddtIndex = 3'h4;
         `DDT_OFS_T1_HIGH: ddtIndex = 3'h5;
         `DDT_OFS_CONFIG: ddtIndex = 3'h6;
         default: ddtIndex = 3'h7;
      endcase
   endfunction : ddtIndex

   // one count step: underflow flag and next count; a single-run timer passes zero as reload
   function automatic logic [16:0] ddtStep(input logic [15:0] c, input logic [15:0] r);
      if (c == 16'h0000) begin
         ddtStep = {1'b1, r};
      end else begin
         ddtStep = {1'b0, c - 16'h0001};
      end
   endfunction : ddtStep

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   ddt_state_t cur_reg;
   ddt_state_t cur_next;

   always_comb begin
      logic [4:0] tick;
      logic rc1, rc8, rc32, rc128, rc512, xtal6, xtal512, slow8;
      logic tk0, tk1, uf1;
      logic set0, set1, clr0, clr1;
      logic access, commit;
      logic [2:0] idx;
      logic [16:0] s;
      tick = 5'h00;
      rc1 = 1'b0;
      rc8 = 1'b0;
      rc32 = 1'b0;
      rc128 = 1'b0;
      rc512 = 1'b0;
      xtal6 = 1'b0;
      xtal512 = 1'b0;
      slow8 = 1'b0;
      tk0 = 1'b0;
      tk1 = 1'b0;
      uf1 = 1'b0;
      set0 = 1'b0;
      set1 = 1'b0;
      clr0 = 1'b0;
      clr1 = 1'b0;
      s = 17'h00000;
      access = 1'b0;
      commit = 1'b0;
      idx = 3'h7;
      cur_next = cur_reg;

      // ----------------------------------------------------------------
      // source synchronisers and dividers
      // ----------------------------------------------------------------
      // sources are sampled by clk_sys, so each must stay below half its rate
      cur_next.syncA = {generalPinTwo, rcSlowClk, crystalClk, lowPowerClk, rcFastClk};
      cur_next.syncB = cur_reg.syncA;
      cur_next.syncC = cur_reg.syncB;
      tick = cur_reg.syncB & ~cur_reg.syncC;

      rc1 = tick[DDT_SRC_RC12];
      rc8 = rc1 && (&cur_reg.rcDiv[2:0]);
      rc32 = rc1 && (&cur_reg.rcDiv[4:0]);
      rc128 = rc1 && (&cur_reg.rcDiv[6:0]);
      rc512 = rc1 && (&cur_reg.rcDiv);
      if (rc1) begin
         cur_next.rcDiv = cur_reg.rcDiv + 9'h001;
      end
      if (tick[DDT_SRC_XTAL]) begin
         xtal6 = (cur_reg.xtalDiv6 == `DDT_XTAL_DIV6_LAST);
         xtal512 = &cur_reg.xtalDiv512;
         cur_next.xtalDiv6 = xtal6 ? 3'h0 : cur_reg.xtalDiv6 + 3'h1;
         cur_next.xtalDiv512 = cur_reg.xtalDiv512 + 9'h001;
      end
      if (tick[DDT_SRC_RC90]) begin
         slow8 = &cur_reg.rc90Div;
         cur_next.rc90Div = cur_reg.rc90Div + 3'h1;
      end

      // ----------------------------------------------------------------
      // counting clock selection
      // ----------------------------------------------------------------
      // with the crystal enabled only crystal based sources remain; other selects count nothing
      if (cur_reg.xtalEn) begin
         unique case (cur_reg.t0Sel)
            3'h0: tk0 = xtal6;
            3'h1: tk0 = xtal512;
            default: tk0 = 1'b0;
         endcase
         tk1 = (cur_reg.t1Sel == 3'h0) && xtal6;
      end else begin
         unique case (cur_reg.t0Sel)
            3'h0: tk0 = rc1;
            3'h1: tk0 = rc8;
            3'h2: tk0 = rc32;
            3'h3: tk0 = rc128;
            3'h4: tk0 = rc512;
            3'h5: tk0 = tick[DDT_SRC_LP4K];
            3'h6: tk0 = cur_reg.t1Uf;
            3'h7: tk0 = slow8;
         endcase
         unique case (cur_reg.t1Sel)
            3'h0: tk1 = rc1;
            3'h1: tk1 = rc8;
            3'h2: tk1 = rc32;
            3'h3: tk1 = rc128;
            3'h4: tk1 = rc512;
            3'h5: tk1 = tick[DDT_SRC_LP4K];
            3'h6: tk1 = tick[DDT_SRC_PIN];
            3'h7: tk1 = 1'b0;
         endcase
      end
      tk0 = tk0 && cur_reg.modEn;
      tk1 = tk1 && cur_reg.modEn;

      // ----------------------------------------------------------------
      // counters per mode
      // ----------------------------------------------------------------
      // a stopped timer simply skips its step and keeps its count
      unique case (cur_reg.modeSel)
         3'h0: begin
            if (cur_reg.run0 && tk0) begin
               s = ddtStep({cur_reg.th0, cur_reg.tl0}, {cur_reg.th1, cur_reg.tl1});
               {cur_next.th0, cur_next.tl0} = s[15:0];
               set0 = s[16];
            end
         end
         3'h1: begin
            if (cur_reg.run0 && tk0) begin
               s = ddtStep({cur_reg.th0, cur_reg.tl0}, 16'h0000);
               {cur_next.th0, cur_next.tl0} = s[15:0];
               set0 = s[16];
               clr0 = s[16];
            end
            if (cur_reg.run1 && tk1) begin
               s = ddtStep({8'h00, cur_reg.tl1}, {8'h00, cur_reg.th1});
               cur_next.tl1 = s[7:0];
               uf1 = s[16];
            end
         end
         3'h2: begin
            if (cur_reg.run0 && tk0) begin
               s = ddtStep({8'h00, cur_reg.tl0}, {8'h00, cur_reg.th0});
               cur_next.tl0 = s[7:0];
               set0 = s[16];
            end
            if (cur_reg.run1 && tk1) begin
               s = ddtStep({8'h00, cur_reg.tl1}, {8'h00, cur_reg.th1});
               cur_next.tl1 = s[7:0];
               uf1 = s[16];
            end
         end
         3'h3: begin
            // both halves of timer 0 share its clock; timer 1 has no run bit left
            if (cur_reg.run0 && tk0) begin
               s = ddtStep({8'h00, cur_reg.tl0}, 16'h0000);
               cur_next.tl0 = s[7:0];
               set0 = s[16];
               clr0 = s[16];
            end
            if (cur_reg.run1 && tk0) begin
               s = ddtStep({8'h00, cur_reg.th0}, 16'h0000);
               cur_next.th0 = s[7:0];
               set1 = s[16];
               clr1 = s[16];
            end
            if (tk1) begin
               s = ddtStep({8'h00, cur_reg.tl1}, {8'h00, cur_reg.th1});
               cur_next.tl1 = s[7:0];
               uf1 = s[16];
            end
         end
         3'h4: begin
            if (cur_reg.run1 && tk1) begin
               s = ddtStep({cur_reg.th1, cur_reg.tl1}, {cur_reg.th0, cur_reg.tl0});
               {cur_next.th1, cur_next.tl1} = s[15:0];
               uf1 = s[16];
            end
         end
         3'h5: begin
            if (cur_reg.run0 && tk0) begin
               s = ddtStep({8'h00, cur_reg.tl0}, {8'h00, cur_reg.th0});
               cur_next.tl0 = s[7:0];
               set0 = s[16];
            end
            if (cur_reg.run1 && tk1) begin
               s = ddtStep({cur_reg.th1, cur_reg.tl1}, 16'h0000);
               {cur_next.th1, cur_next.tl1} = s[15:0];
               uf1 = s[16];
               clr1 = s[16];
            end
         end
         3'h6: begin
            if (cur_reg.run0 && tk0) begin
               s = ddtStep({cur_reg.th0, cur_reg.tl0}, 16'h0000);
               {cur_next.th0, cur_next.tl0} = s[15:0];
               set0 = s[16];
               clr0 = s[16];
            end
            if (cur_reg.run1 && tk1) begin
               s = ddtStep({cur_reg.th1, cur_reg.tl1}, 16'h0000);
               {cur_next.th1, cur_next.tl1} = s[15:0];
               uf1 = s[16];
               clr1 = s[16];
            end
         end
         3'h7: begin
            // reserved layout: counters freeze
         end
      endcase
      if (cur_reg.modeSel != 3'h3) begin
         set1 = uf1;
      end
      cur_next.t1Uf = uf1;
      cur_next.bitRate = uf1 && (cur_reg.modeSel inside {3'h1, 3'h2, 3'h3});
      if (clr0) begin
         cur_next.run0 = 1'b0;
      end
      if (clr1) begin
         cur_next.run1 = 1'b0;
      end

      // ----------------------------------------------------------------
      // apb slave: one wait state, write lands on the edge that samples pready
      // ----------------------------------------------------------------
      access = psel && penable;
      commit = access && cur_reg.pready;
      idx = ddtIndex(paddr);
      cur_next.pready = access && !cur_reg.pready;
      cur_next.pslverr = access && !cur_reg.pready && (idx == 3'h7);
      if (access && !cur_reg.pready) begin
         unique case (idx)
            3'h0: cur_next.prdata = {28'h0000000, cur_reg.full1, cur_reg.run1, cur_reg.full0,
                                     cur_reg.run0};
            3'h1: cur_next.prdata = {22'h000000, cur_reg.xtalEn, cur_reg.t1Sel, cur_reg.t0Sel,
                                     cur_reg.modeSel};
            3'h2: cur_next.prdata = {24'h000000, cur_reg.tl0};
            3'h3: cur_next.prdata = {24'h000000, cur_reg.th0};
            3'h4: cur_next.prdata = {24'h000000, cur_reg.tl1};
            3'h5: cur_next.prdata = {24'h000000, cur_reg.th1};
            3'h6: cur_next.prdata = {28'h0000000, cur_reg.sysDiv, cur_reg.modEn};
            3'h7: cur_next.prdata = `DDT_RESET_WORD;
         endcase
      end
      // applied after the count step, so a software write wins over a same-cycle step, except for the full flags
      if (commit && pwrite) begin
         unique case (idx)
            3'h0: begin
               cur_next.run0 = pwdata[`DDT_CTL_T0_RUN];
               cur_next.run1 = pwdata[`DDT_CTL_T1_RUN];
               cur_next.full0 = pwdata[`DDT_CTL_T0_FULL];
               cur_next.full1 = pwdata[`DDT_CTL_T1_FULL];
            end
            3'h1: begin
               cur_next.modeSel = pwdata[`DDT_MOD_MODE_LSB +: 3];
               cur_next.t0Sel = pwdata[`DDT_MOD_T0SEL_LSB +: 3];
               cur_next.t1Sel = pwdata[`DDT_MOD_T1SEL_LSB +: 3];
               cur_next.xtalEn = pwdata[`DDT_MOD_XTAL_EN];
            end
            3'h2: cur_next.tl0 = pwdata[7:0];
            3'h3: cur_next.th0 = pwdata[7:0];
            3'h4: cur_next.tl1 = pwdata[7:0];
            3'h5: cur_next.th1 = pwdata[7:0];
            3'h6: begin
               cur_next.modEn = pwdata[`DDT_CFG_ENABLE];
               cur_next.sysDiv = pwdata[`DDT_CFG_SYSDIV_LSB +: 3];
            end
            3'h7: begin
            end
         endcase
      end
      // an underflow in the cycle of a clearing write still leaves the flag set
      cur_next.full0 = cur_next.full0 || set0;
      cur_next.full1 = cur_next.full1 || set1;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cur_reg <= '0;
      end else begin
         cur_reg <= cur_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign prdata = cur_reg.prdata;
   assign pready = cur_reg.pready;
   assign pslverr = cur_reg.pslverr;
   assign bitRateTick = cur_reg.bitRate;
   assign systemClockDivider = cur_reg.sysDiv;

endmodule : ddt_dual_down_timer

// [rtl/ddt_pkg.sv]
// types shared by the dual down timer
package ddt_pkg;

   typedef logic [31:0] ddt_word_t;
   typedef logic [7:0] ddt_addr_t;

   // clock sources in synchroniser bit order
   typedef enum logic [2:0] {
      DDT_SRC_RC12,
      DDT_SRC_LP4K,
      DDT_SRC_XTAL,
      DDT_SRC_RC90,
      DDT_SRC_PIN
   } ddt_src_t;

   typedef struct packed {
      logic [4:0] syncA;
      logic [4:0] syncB;
      logic [4:0] syncC;
      logic [8:0] rcDiv;
      logic [2:0] xtalDiv6;
      logic [8:0] xtalDiv512;
      logic [2:0] rc90Div;
      logic t1Uf;
      logic [2:0] modeSel;
      logic [2:0] t0Sel;
      logic [2:0] t1Sel;
      logic xtalEn;
      logic modEn;
      logic [2:0] sysDiv;
      logic run0;
      logic full0;
      logic run1;
      logic full1;
      logic [7:0] tl0;
      logic [7:0] th0;
      logic [7:0] tl1;
      logic [7:0] th1;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic bitRate;
   } ddt_state_t;

endpackage : ddt_pkg

// [rtl/ddt_timer_map.svh]
// register offsets, field positions and reset values of the dual down timer
`ifndef DDT_TIMER_MAP_SVH
`define DDT_TIMER_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DDT_OFS_CONTROL 8'h00
`define DDT_OFS_MODE 8'h04
`define DDT_OFS_T0_LOW 8'h08
`define DDT_OFS_T0_HIGH 8'h0C
`define DDT_OFS_T1_LOW 8'h10
`define DDT_OFS_T1_HIGH 8'h14
`define DDT_OFS_CONFIG 8'h18

// ----------------------------------------------------------------
// timer_control_reg fields
// ----------------------------------------------------------------
`define DDT_CTL_T0_RUN 0
`define DDT_CTL_T0_FULL 1
`define DDT_CTL_T1_RUN 2
`define DDT_CTL_T1_FULL 3

// ----------------------------------------------------------------
// timer_mode_reg fields
// ----------------------------------------------------------------
`define DDT_MOD_MODE_LSB 0
`define DDT_MOD_T0SEL_LSB 3
`define DDT_MOD_T1SEL_LSB 6
`define DDT_MOD_XTAL_EN 9

// ----------------------------------------------------------------
// config_reg_two fields
// ----------------------------------------------------------------
`define DDT_CFG_ENABLE 0
`define DDT_CFG_SYSDIV_LSB 1

// ----------------------------------------------------------------
// reset values and divider counts
// ----------------------------------------------------------------
`define DDT_RESET_BYTE 8'h00
`define DDT_RESET_WORD 32'h0000_0000
`define DDT_XTAL_DIV6_LAST 3'h5

`endif

// [test/ddt_dual_down_timer_props.sv]
// port assertions and cover points for the dual down timer
`timescale 1ns/1ps
module ddt_timer_props (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire ddt_pkg::ddt_addr_t paddr,
   input wire ddt_pkg::ddt_word_t pwdata,
   input wire ddt_pkg::ddt_word_t prdata,
   input wire logic pready,
   input wire logic pslverr,
   // counting sources
   input wire logic rcFastClk,
   input wire logic lowPowerClk,
   input wire logic crystalClk,
   input wire logic rcSlowClk,
   input wire logic generalPinTwo,
   // status
   input wire logic bitRateTick,
   input wire logic [2:0] systemClockDivider
);
   import ddt_pkg::*;
   logic unmapped;
   logic cfgWrite;
   logic [2:0] modeQ;
   logic enQ;
   logic [2:0] divW;

   assign divW = pwdata[3:1];

   assign unmapped = (paddr > 8'h18) || (paddr[1:0] != 2'h0);
   assign cfgWrite = pready && pwrite && (paddr == 8'h18);

   // shadow of mode and enable, updated where a write lands
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         modeQ <= 3'h0;
         enQ <= 1'b0;
      end else if (pready && pwrite && psel && penable) begin
         if (paddr == 8'h04) modeQ <= pwdata[2:0];
         if (paddr == 8'h18) enQ <= pwdata[0];
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   a_ready_after_take: assert property (psel && penable && !pready |=> pready)
      else $error("no pready one cycle after access");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("pready outside an access");
   a_err_on_unmapped: assert property (pready |-> pslverr == unmapped)
      else $error("pslverr does not match address");
   a_unmapped_reads_zero: assert property (pready && !pwrite && unmapped |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_divider_update: assert property (cfgWrite |=> systemClockDivider == $past(divW))
      else $error("divider did not follow write");
   a_divider_hold: assert property (!cfgWrite |=> $stable(systemClockDivider))
      else $error("divider changed without write");
   a_tick_single: assert property (bitRateTick |=> !bitRateTick)
      else $error("bit rate tick wider than one cycle");
   a_tick_mode_enable: assert property (bitRateTick |->
      $past(modeQ) inside {3'h1, 3'h2, 3'h3} && $past(enQ))
      else $error("bit rate tick in wrong mode or disabled");

   c_mode_write: cover property (pready && pwrite && paddr == 8'h04);
   c_bit_rate: cover property (bitRateTick);
   c_refused: cover property (pready && pslverr);
endmodule : ddt_timer_props

bind ddt_dual_down_timer ddt_timer_props ddt_timer_props_inst (
   .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .rcFastClk(rcFastClk), .lowPowerClk(lowPowerClk), .crystalClk(crystalClk),
   .rcSlowClk(rcSlowClk), .generalPinTwo(generalPinTwo), .bitRateTick(bitRateTick),
   .systemClockDivider(systemClockDivider)
);

// [test/testbench.sv]
// self-checking bench for the dual down timer
`timescale 1ns/1ps
module testbench;
   import ddt_pkg::*;
   typedef struct packed {
      logic [2:0] md;
      ddt_addr_t lo;
      ddt_addr_t hi;
      ddt_addr_t rlo;
      logic [1:0] rb;
      logic rel;
   } ddt_case_t;
   logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, bitRateTick;
   ddt_addr_t paddr;
   ddt_word_t pwdata, prdata;
   logic [4:0] srcLvl;
   logic [2:0] systemClockDivider;
   int failures = 0;
   int n_compared = 0;
   int nRate = 0;
   // counter, high byte (FF none), reload low (FF none), run bit, reload
   ddt_case_t cs [9] = '{
      '{3'h0, 8'h08, 8'h0C, 8'h10, 2'h0, 1'b1},
      '{3'h1, 8'h08, 8'h0C, 8'hFF, 2'h0, 1'b0},
      '{3'h1, 8'h10, 8'hFF, 8'h14, 2'h2, 1'b1},
      '{3'h2, 8'h08, 8'hFF, 8'h0C, 2'h0, 1'b1},
      '{3'h3, 8'h0C, 8'hFF, 8'hFF, 2'h2, 1'b0},
      '{3'h4, 8'h10, 8'h14, 8'h08, 2'h2, 1'b1},
      '{3'h5, 8'h08, 8'hFF, 8'h0C, 2'h0, 1'b1},
      '{3'h5, 8'h10, 8'h14, 8'hFF, 2'h2, 1'b0},
      '{3'h6, 8'h10, 8'h14, 8'hFF, 2'h2, 1'b0}};

   ddt_dual_down_timer ddt_dual_down_timer_inst (
      .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rcFastClk(srcLvl[0]), .lowPowerClk(srcLvl[1]), .crystalClk(srcLvl[2]),
      .rcSlowClk(srcLvl[3]), .generalPinTwo(srcLvl[4]), .bitRateTick(bitRateTick),
      .systemClockDivider(systemClockDivider));

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // bit rate ticks seen on the output
   always @(posedge clk_sys) begin
      if (bitRateTick === 1'b1) nRate <= nRate + 1;
   end

   // ----------------------------------------------------------------
   // checks and expectations
   // ----------------------------------------------------------------
   task automatic results;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : results

   task automatic chk(input string what, input ddt_word_t exp, input ddt_word_t got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   function automatic logic bad(input ddt_addr_t a);
      return (a > 8'h18) || (a[1:0] != 2'h0);
   endfunction : bad

   function automatic ddt_word_t mask(input ddt_addr_t a);
      case (a)
         8'h00, 8'h18: return 32'hF;
         8'h04: return 32'h3FF;
         8'h08, 8'h0C, 8'h10, 8'h14: return 32'hFF;
         default: return 32'h0;
      endcase
   endfunction : mask

   // returns run, full and count after n source ticks
   function automatic logic [17:0] model(input logic [15:0] c, input logic [15:0] r,
                                         input int n, input logic rel);
      logic run;
      logic full;
      run = 1'b1;
      full = 1'b0;
      for (int k = 0; k < n; k++) begin
         if (run && c != 16'h0) c--;
         else if (run) begin
            full = 1'b1;
            if (rel) c = r;
            else run = 1'b0;
         end
      end
      return {run, full, c};
   endfunction : model

   // ----------------------------------------------------------------
   // drivers
   // ----------------------------------------------------------------
   task automatic apb(input logic w, input ddt_addr_t a, input ddt_word_t d,
                      output ddt_word_t q);
      int i;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk_sys);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1) begin
         failures++;
         results();
      end
      q = prdata;
      chk("pslverr", 32'(bad(a)), 32'(pslverr));
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask : apb

   task automatic wr(input ddt_addr_t a, input ddt_word_t d);
      ddt_word_t q;
      apb(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input ddt_addr_t a, input ddt_word_t e);
      ddt_word_t q;
      apb(1'b0, a, 32'h0, q);
      chk("prdata", e, q);
   endtask : rd

   // source levels stay put for three system clocks on each side
   task automatic tick(input int idx, input int n);
      repeat (n) begin
         srcLvl[idx] <= 1'b1;
         repeat (3) @(posedge clk_sys);
         srcLvl[idx] <= 1'b0;
         repeat (3) @(posedge clk_sys);
      end
      repeat (3) @(posedge clk_sys);
   endtask : tick

   task automatic srcCase(input ddt_word_t sel, input logic t1, input int idx, input int n);
      ddt_addr_t a;
      a = t1 ? 8'h10 : 8'h08;
      wr(8'h04, 32'h2 | (sel << (t1 ? 6 : 3)));
      wr(a, 32'h5);
      wr(8'h00, t1 ? 32'h4 : 32'h1);
      tick(0, 1);
      tick(idx, n);
      rd(a, 32'h4);
      wr(8'h00, 32'h0);
   endtask : srcCase

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [17:0] e;
      logic [7:0] lo, hi, rl;
      int n;
      ddt_addr_t a;
      ddt_word_t d;
      reset <= 1'b1;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 8'h00;
      pwdata <= 32'h0;
      srcLvl <= 5'h00;
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      void'($urandom(32'h5EDB841F));
      for (int k = 0; k < 7; k++) rd(8'(k * 4), 32'h0);
      $display("test reset values done");
      for (int k = 0; k < 10; k++) begin
         a = (k == 9) ? 8'h06 : 8'(k * 4);
         d = $urandom;
         wr(a, d);
         rd(a, d & mask(a));
         if (a == 8'h18) chk("divider", {29'h0, d[3:1]}, 32'(systemClockDivider));
      end
      $display("test register access done");
      wr(8'h18, 32'h0);
      wr(8'h04, 32'h6);
      wr(8'h08, 32'h5);
      wr(8'h0C, 32'h0);
      wr(8'h00, 32'h1);
      tick(0, 3);
      rd(8'h08, 32'h5);
      $display("test module disabled done");
      foreach (cs[i]) begin
         for (int p = 0; p < 2; p++) begin
            lo = 8'($urandom % 3);
            hi = (cs[i].hi != 8'hFF) ? 8'(p) : 8'h00;
            rl = 8'($urandom % 3);
            n = $urandom % 5 + 1;
            wr(8'h18, 32'h1);
            wr(8'h04, {29'h0, cs[i].md});
            wr(8'h00, 32'h0);
            wr(cs[i].lo, {24'h0, lo});
            if (cs[i].hi != 8'hFF) wr(cs[i].hi, {24'h0, hi});
            if (cs[i].rlo != 8'hFF) wr(cs[i].rlo, {24'h0, rl});
            if (cs[i].rlo != 8'hFF && cs[i].hi != 8'hFF) wr(cs[i].rlo + 8'h04, 32'h0);
            wr(8'h00, 32'h1 << cs[i].rb);
            tick(0, n);
            e = model({hi, lo}, {8'h00, rl}, n, cs[i].rel);
            rd(cs[i].lo, {24'h0, e[7:0]});
            if (cs[i].hi != 8'hFF) rd(cs[i].hi, {24'h0, e[15:8]});
            rd(8'h00, (32'(e[17]) << cs[i].rb) | (32'(e[16]) << (cs[i].rb + 1)));
            wr(8'h00, 32'h0);
            tick(0, 2);
            rd(cs[i].lo, {24'h0, e[7:0]});
            rd(8'h00, 32'h0);
         end
      end
      $display("test timer modes done");
      srcCase(32'h5, 1'b1, 1, 1);
      srcCase(32'h6, 1'b1, 4, 1);
      srcCase(32'h5, 1'b0, 1, 1);
      // crystal /6 for each timer, then slow rc /8 for timer 0
      srcCase(32'h8, 1'b1, 2, 6);
      srcCase(32'h40, 1'b0, 2, 6);
      srcCase(32'h7, 1'b0, 3, 8);
      $display("test clock sources done");
      wr(8'h04, 32'h32);
      wr(8'h10, 32'h0);
      wr(8'h14, 32'h0);
      wr(8'h08, 32'h5);
      wr(8'h00, 32'h5);
      n = nRate;
      tick(0, 2);
      chk("bit rate ticks", 32'h2, 32'(nRate - n));
      rd(8'h08, 32'h3);
      rd(8'h00, 32'hD);
      wr(8'h00, 32'h0);
      $display("test underflow chain done");
      results();
   end
endmodule : testbench
